// ### src/wdt_regs.vh
// constants for the window and standard watchdog supervisor
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// ------------------------------------------------------------
// clock and timing figures
// ------------------------------------------------------------
`define CLK_PERIOD_NS    50
`define SVC_MIN_US       100
`define NS_PER_US        1000
`define LO_NS_PER_OHM    500
`define SCALE_RATIO      5
`define INIT_MULT        3'd3
`define HALF_DIV         2
`define NINTH_DIV        9
`define HOLD_DIV         5
// ------------------------------------------------------------
// register offsets and fields
// ------------------------------------------------------------
`define REG_TIMING       8'h00
`define REG_STATUS       8'h04
`define REG_CLEAR        8'h08
`define REG_IRQEN        8'h0c
`define REG_STATE        8'h10
`define OHMS_W           20
`define OHMS_RST         20'h04e20
`define EVT_W            3
`define EVT_FAULT        0
`define EVT_RESFLT       1
`define EVT_SERVICE      2
`define PIN_W            9
`endif

// ### src/sync_stages.v
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module sync_stages #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async,
  output wire [WIDTH-1:0] synced
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] hold_r;

  // first stage is read only by the second stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      hold_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async;
      hold_r <= meta_r;
    end
  end

  assign synced = hold_r;
endmodule // sync_stages

// ### src/service_qualifier.v
// rising edge detector with minimum high time for the service pin
`timescale 1ns/1ns
module service_qualifier #(
  parameter CNT_W   = 16,
  parameter MIN_CYC = 2000
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire level,
  output wire valid
);
  localparam [CNT_W-1:0] MIN_C = MIN_CYC;
  reg             prev_r;
  reg             armed_r;
  reg [CNT_W-1:0] high_r;
  reg             valid_r;

  // a pulse counts once, when it has stayed high long enough
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
      high_r  <= {CNT_W{1'b0}};
      valid_r <= 1'b0;
    end else begin
      prev_r  <= level;
      valid_r <= 1'b0;
      if (!level) begin
        armed_r <= 1'b0;
        high_r  <= {CNT_W{1'b0}};
      end else if (!prev_r) begin
        armed_r <= 1'b1;
        high_r  <= {{(CNT_W-1){1'b0}}, 1'b1};
        valid_r <= (MIN_C <= 1);
      end else if (armed_r) begin
        high_r <= high_r + 1'b1;
        if (high_r + 1'b1 >= MIN_C) begin
          valid_r <= 1'b1; // one strobe per rising edge
          armed_r <= 1'b0;
        end
      end
    end
  end

  assign valid = valid_r;
endmodule // service_qualifier

// ### src/window_watchdog.v
// window / standard watchdog supervisor with register port
`timescale 1ns/1ns
`include "wdt_regs.vh"
// Function
// - type select low gives window watchdog
// - type select high gives standard watchdog
// - period is resistor times per-ohm time
// - scale select high makes period five-fold
// - first open window lasts eight periods
// - ratio low: open and closed halves
// - ratio high: open eight ninths of period
// - window mode faults: early or missed service
// - standard mode faults only on missed window
// - fault pulls output low one fifth period
// - resistor short/open holds output low
// - no resistor check while disabled
// - enable low turns watchdog on under power-good
// - power-good low: disabled, output released
// - re-initialise on enable or fault release
// - service in init: window mode starts closed then open, standard mode goes straight to open
// - rising edge detect, one service per edge
module window_watchdog #(
  parameter CNT_W          = 32,
  parameter CYC_PER_OHM_LO = `LO_NS_PER_OHM / `CLK_PERIOD_NS,
  parameter SVC_MIN_CYC    =
    (`SVC_MIN_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  addr,
  input  wire [31:0] wrData,
  input  wire        wrStb,
  input  wire        rdStb,
  output wire [31:0] rdData,
  output wire        irq,
  input  wire        watchdogTypeSelect,
  input  wire        periodScaleSelect,
  input  wire        windowRatioSelect,
  input  wire        timingResistorShort,
  input  wire        timingResistorOpen,
  input  wire        serviceInput,
  input  wire        watchdogEnable_n,
  input  wire        powerGood,
  input  wire        faultOutputIn,
  output wire        faultOutputOut,
  output wire        faultOutputOe
);
  // ------------------------------------------------------------
  // states, one-hot
  // ------------------------------------------------------------
  localparam [5:0] ST_IDLE   = 6'h01;
  localparam [5:0] ST_INIT   = 6'h02;
  localparam [5:0] ST_CLOSED = 6'h04;
  localparam [5:0] ST_OPEN   = 6'h08;
  localparam [5:0] ST_FAULT  = 6'h10;
  localparam [5:0] ST_RESFLT = 6'h20;
  localparam [CNT_W-1:0] LO_MULT = CYC_PER_OHM_LO;
  localparam [CNT_W-1:0] HI_MULT = CYC_PER_OHM_LO * `SCALE_RATIO;

  // ------------------------------------------------------------
  // pin synchronisers and service qualification
  // ------------------------------------------------------------
  wire [`PIN_W-1:0] pinS;
  wire              typeS;
  wire              scaleS;
  wire              ratioS;
  wire              shortS;
  wire              openS;
  wire              serviceS;
  wire              enableNS;
  wire              pgS;
  wire              lineS;
  wire              svcValid;

  sync_stages #(
    .WIDTH (`PIN_W)
  ) u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .async  ({faultOutputIn, powerGood, watchdogEnable_n, serviceInput,
              timingResistorOpen, timingResistorShort, windowRatioSelect,
              periodScaleSelect, watchdogTypeSelect}),
    .synced (pinS)
  );

  assign typeS    = pinS[0];
  assign scaleS   = pinS[1];
  assign ratioS   = pinS[2];
  assign shortS   = pinS[3];
  assign openS    = pinS[4];
  assign serviceS = pinS[5];
  assign enableNS = pinS[6];
  assign pgS      = pinS[7];
  assign lineS    = pinS[8];

  service_qualifier #(
    .CNT_W   (16),
    .MIN_CYC (SVC_MIN_CYC)
  ) u_svc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .level (serviceS),
    .valid (svcValid)
  );

  // ------------------------------------------------------------
  // registers and window arithmetic
  // ------------------------------------------------------------
  reg [`OHMS_W-1:0] ohms_r;
  reg [`EVT_W-1:0]  status_r;
  reg [`EVT_W-1:0]  irqEn_r;
  reg [31:0]        rdData_r;
  reg [5:0]         state_r;
  reg [5:0]         state_nxt;
  reg [CNT_W-1:0]   cnt_r;
  reg [CNT_W-1:0]   cnt_nxt;
  reg               enPrev_r;
  reg               pullOe_r;
  reg [`EVT_W-1:0]  evt;

  wire              enabled;
  wire              enableRise;
  wire              resFault;
  wire [CNT_W-1:0]  periodCyc;
  wire [CNT_W-1:0]  initCyc;
  wire [CNT_W-1:0]  closedCyc;
  wire [CNT_W-1:0]  openCyc;
  wire [CNT_W-1:0]  holdCyc;
  wire              expired;

  assign enabled    = pgS & ~enableNS;
  assign enableRise = enabled & ~enPrev_r;
  assign resFault   = enabled & (shortS | openS);

  assign periodCyc = {{(CNT_W-`OHMS_W){1'b0}}, ohms_r} *
                     (scaleS ? HI_MULT : LO_MULT);
  assign initCyc   = periodCyc << `INIT_MULT;
  assign closedCyc = ratioS ? periodCyc / `NINTH_DIV
                            : periodCyc / `HALF_DIV;
  assign openCyc   = periodCyc - closedCyc;
  assign holdCyc   = periodCyc / `HOLD_DIV;
  assign expired   = (cnt_r == {CNT_W{1'b0}});

  // counter loads hold value minus one so a window lasts val cycles
  function [CNT_W-1:0] ld;
    input [CNT_W-1:0] val;
    begin
      ld = (val == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : val - 1'b1;
    end
  endfunction

  // ------------------------------------------------------------
  // window sequencer
  // ------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = expired ? cnt_r : cnt_r - 1'b1;
    evt       = {`EVT_W{1'b0}};
    if (!enabled) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = {CNT_W{1'b0}};
    end else if (resFault) begin
      state_nxt = ST_RESFLT;
      evt[`EVT_RESFLT] = (state_r != ST_RESFLT);
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_INIT;
          cnt_nxt   = ld(initCyc);
        end
        ST_INIT: begin
          if (svcValid) begin
            evt[`EVT_SERVICE] = 1'b1;
            if (!typeS) begin
              state_nxt = ST_CLOSED;
              cnt_nxt   = ld(closedCyc);
            end else begin
              state_nxt = ST_OPEN;
              cnt_nxt   = ld(periodCyc);
            end
          end else if (expired) begin
            state_nxt = ST_FAULT;
            cnt_nxt   = ld(holdCyc);
            evt[`EVT_FAULT] = 1'b1;
          end
        end
        ST_CLOSED: begin
          if (svcValid) begin
            state_nxt = ST_FAULT;
            cnt_nxt   = ld(holdCyc);
            evt[`EVT_FAULT] = 1'b1;
          end else if (expired) begin
            state_nxt = ST_OPEN;
            cnt_nxt   = ld(openCyc);
          end
        end
        ST_OPEN: begin
          if (svcValid) begin
            evt[`EVT_SERVICE] = 1'b1;
            if (typeS) begin
              state_nxt = ST_OPEN;
              cnt_nxt   = ld(periodCyc);
            end else begin
              state_nxt = ST_CLOSED;
              cnt_nxt   = ld(closedCyc);
            end
          end else if (expired) begin
            state_nxt = ST_FAULT;
            cnt_nxt   = ld(holdCyc);
            evt[`EVT_FAULT] = 1'b1;
          end
        end
        ST_FAULT: begin
          if (expired) begin
            state_nxt = ST_INIT;
            cnt_nxt   = ld(initCyc);
          end
        end
        ST_RESFLT: begin
          // output rises once the resistor recovers: start over
          state_nxt = ST_INIT;
          cnt_nxt   = ld(initCyc);
        end
        default: begin
          state_nxt = ST_IDLE;
          cnt_nxt   = {CNT_W{1'b0}};
        end
      endcase
    end
    // a fresh enable restarts the long first window unless the resistor is short or open
    if (enableRise && !resFault) begin
      state_nxt = ST_INIT;
      cnt_nxt   = ld(initCyc);
    end
  end

  // state, counter and pull-down driver
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cnt_r    <= {CNT_W{1'b0}};
      enPrev_r <= 1'b0;
      pullOe_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      enPrev_r <= enabled;
      pullOe_r <= (state_nxt == ST_FAULT) || (state_nxt == ST_RESFLT);
    end
  end

  // open drain: only ever pulls low, released otherwise
  assign faultOutputOut = 1'b0;
  assign faultOutputOe  = pullOe_r;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // writes: timing resistor, clear and enable; set beats clear
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ohms_r   <= `OHMS_RST;
      status_r <= {`EVT_W{1'b0}};
      irqEn_r  <= {`EVT_W{1'b0}};
    end else begin
      if (wrStb && addr == `REG_TIMING) begin
        ohms_r <= wrData[`OHMS_W-1:0];
      end
      if (wrStb && addr == `REG_IRQEN) begin
        irqEn_r <= wrData[`EVT_W-1:0];
      end
      if (wrStb && addr == `REG_CLEAR) begin
        status_r <= (status_r & ~wrData[`EVT_W-1:0]) | evt;
      end else begin
        status_r <= status_r | evt;
      end
    end
  end

  // read data stand for one cycle after the strobe, else zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 32'h00000000;
    end else if (rdStb) begin
      case (addr)
        `REG_TIMING: rdData_r <= {{(32-`OHMS_W){1'b0}}, ohms_r};
        `REG_STATUS: rdData_r <= {{(32-`EVT_W){1'b0}}, status_r};
        `REG_IRQEN:  rdData_r <= {{(32-`EVT_W){1'b0}}, irqEn_r};
        `REG_STATE:  rdData_r <= {16'h0000, lineS, pgS, enableNS,
                                  openS, shortS, ratioS, scaleS, typeS,
                                  2'b00, state_r};
        default:     rdData_r <= 32'h00000000;
      endcase
    end else begin
      rdData_r <= 32'h00000000;
    end
  end

  assign rdData = rdData_r;
  // level interrupt while any enabled sticky bit is set
  assign irq    = |(status_r & irqEn_r);
endmodule // window_watchdog

// ### tb/window_watchdog_asserts.sv
// port checker for the window watchdog supervisor
`timescale 1ns/1ns
`include "wdt_regs.vh"
module window_watchdog_asserts #(
  parameter CYC_PER_OHM_LO = 10
) (
  input wire        mclk,
  input wire        rst_n,
  input wire [7:0]  addr,
  input wire [31:0] wrData,
  input wire        wrStb,
  input wire        rdStb,
  input wire [31:0] rdData,
  input wire        periodScaleSelect,
  input wire        timingResistorShort,
  input wire        timingResistorOpen,
  input wire        watchdogEnable_n,
  input wire        powerGood,
  input wire        faultOutputOut,
  input wire        faultOutputOe
);
  reg  [19:0] ohms_r;
  reg  [31:0] hold_r;
  reg         cut_r;
  wire [31:0] holdLen = ohms_r * CYC_PER_OHM_LO
    * (periodScaleSelect ? `SCALE_RATIO : 1) / `HOLD_DIV;
  // shadow of the period setting and length of each low pulse;
  // cut_r marks pulses ended early by resistor, power or enable events
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ohms_r <= `OHMS_RST;
      hold_r <= 32'h0;
      cut_r  <= 1'b0;
    end else begin
      if (wrStb && addr == `REG_TIMING)
        ohms_r <= wrData[19:0];
      hold_r <= faultOutputOe ? hold_r + 32'h1 : 32'h0;
      cut_r  <= faultOutputOe & (cut_r | timingResistorShort
        | timingResistorOpen | !powerGood | watchdogEnable_n);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rd_idle_zero: assert property (!$past(rdStb) |-> rdData == 32'h0)
    else $error("read data not zero outside read slot");
  a_clear_reads_zero: assert property (
    rdStb && addr == `REG_CLEAR |=> rdData == 32'h0)
    else $error("clear register read not zero");
  a_drive_low_only: assert property (faultOutputOut == 1'b0)
    else $error("fault line driven high");
  a_pg_low_release: assert property (
    !powerGood [*5] |-> !faultOutputOe)
    else $error("fault line pulled while power not good");
  a_off_no_fault: assert property (
    watchdogEnable_n [*5] |-> !faultOutputOe)
    else $error("fault line pulled while disabled");
  a_resistor_hold: assert property (
    (powerGood && !watchdogEnable_n
     && (timingResistorShort || timingResistorOpen)) [*6]
    |-> faultOutputOe)
    else $error("resistor fault not held on line");
  a_hold_width: assert property (
    $fell(faultOutputOe) && !cut_r |-> hold_r == holdLen)
    else $error("fault pulse width wrong");
  a_fault_gap: assert property (
    $fell(faultOutputOe) |-> !faultOutputOe [*8])
    else $error("fault pulse too soon after release");
  a_fault_needs_pg: assert property (
    $rose(faultOutputOe) |-> $past(powerGood, 3))
    else $error("fault raised without power good");
endmodule // window_watchdog_asserts

bind window_watchdog window_watchdog_asserts #(
  .CYC_PER_OHM_LO(CYC_PER_OHM_LO)
) u_chk (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .periodScaleSelect(periodScaleSelect),
  .timingResistorShort(timingResistorShort),
  .timingResistorOpen(timingResistorOpen),
  .watchdogEnable_n(watchdogEnable_n), .powerGood(powerGood),
  .faultOutputOut(faultOutputOut), .faultOutputOe(faultOutputOe)
);

// ### tb/mcu_model.sv
// servicing controller model and the pulled-up fault line
`timescale 1ns/1ns
module mcu_model (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       svcGo,
  input  wire [7:0] svcLen,
  input  wire       enReq,
  input  wire       faultOutputOut,
  input  wire       faultOutputOe,
  output wire       serviceInput,
  output wire       watchdogEnable_n,
  output wire       faultLine
);
  reg       svc_r;
  reg       enN_r;
  reg [7:0] left_r;
  // open drain: the pull-up wins whenever the device lets go
  assign faultLine        = faultOutputOe ? faultOutputOut : 1'b1;
  assign serviceInput     = svc_r;
  assign watchdogEnable_n = enN_r;
  // pulse held svcLen cycles, enable from controller
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      svc_r  <= 1'b0;
      enN_r  <= 1'b1;
      left_r <= 8'h00;
    end else begin
      enN_r <= !enReq;
      if (svcGo) begin
        svc_r  <= 1'b1;
        left_r <= svcLen;
      end else if (left_r > 8'h01) begin
        left_r <= left_r - 8'h01;
      end else begin
        svc_r <= 1'b0;
      end
    end
  end
endmodule // mcu_model

// ### tb/tb.sv
// self-checking bench for the window watchdog supervisor
`timescale 1ns/1ns
`include "wdt_regs.vh"
module tb;
  localparam int SVC = 4;
  localparam int T   = 200; // 20 ohms at 10 cycles per ohm
  localparam int TOL = 12;
  logic        mclk, rst_n, wrStb, rdStb, svcGo, enReq, pg;
  logic        typeSel, scaleSel, ratioSel, rShort, rOpen;
  logic [7:0]  addr, svcLen;
  logic [31:0] wrData;
  wire  [31:0] rdData;
  wire         irq, svc, enN, line, oeOut, oe;
  int          n_fail, n_tests, cyc, refCyc, riseCyc, expW;
  bit          mon, rdSeen, oeLast;
  logic [31:0] rdQ[$];
  int          dQ[$], wQ[$];

  window_watchdog #(.CYC_PER_OHM_LO(10), .SVC_MIN_CYC(SVC)) dut (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
    .watchdogTypeSelect(typeSel), .periodScaleSelect(scaleSel),
    .windowRatioSelect(ratioSel), .timingResistorShort(rShort),
    .timingResistorOpen(rOpen), .serviceInput(svc),
    .watchdogEnable_n(enN), .powerGood(pg), .faultOutputIn(line),
    .faultOutputOut(oeOut), .faultOutputOe(oe));
  mcu_model pm (
    .mclk(mclk), .rst_n(rst_n), .svcGo(svcGo), .svcLen(svcLen),
    .enReq(enReq), .faultOutputOut(oeOut), .faultOutputOe(oe),
    .serviceInput(svc), .watchdogEnable_n(enN), .faultLine(line));

  task chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task chkRange(string n, int lo, int g);
    n_tests++;
    if (g < lo || g > lo + TOL) begin
      n_fail++;
      $display("mismatch %s exp %0d got %0d", n, lo, g);
    end
  endtask
  task print_verdict;
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a; wrData <= d; wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    addr <= a; rdStb <= 1'b1; rdQ.push_back(e);
    @(posedge mclk);
    rdStb <= 1'b0;
  endtask
  // random pulse length, never below the qualifying minimum
  task service(int gap);
    repeat (gap) @(posedge mclk);
    svcLen <= 8'(SVC + $urandom % 6); svcGo <= 1'b1; refCyc = cyc;
    @(posedge mclk);
    svcGo <= 1'b0;
  endtask
  // a line that never moves counts as a mismatch, not a silent pass
  task waitOe(logic v);
    for (int i = 0; i < 20000 && oe !== v; i++) @(negedge mclk);
    chk("fault line", v, oe);
  endtask
  task fault(int d, int w);
    dQ.push_back(d); wQ.push_back(w);
    waitOe(1'b1); waitOe(1'b0);
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // cycle count and the output watcher that pops expectations
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rdSeen) chk("rdData", rdQ.pop_front(), rdData);
    rdSeen <= rdStb;
    if (mon && oe && !oeLast) begin
      if (dQ.size() == 0) chk("unexpected fault", 0, 1);
      else chkRange("fault delay", dQ.pop_front(), cyc - refCyc);
      if (wQ.size() != 0) expW = wQ.pop_front();
      riseCyc = cyc;
    end
    if (mon && !oe && oeLast) chk("width", expW, cyc - riseCyc);
    oeLast <= oe;
  end
  // hang guard well beyond the expected run of some 11000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    print_verdict;
  end

  initial begin
    void'($urandom(78605));
    {rst_n, wrStb, rdStb, svcGo, enReq, pg, typeSel} = 7'h0;
    {scaleSel, ratioSel, rShort, rOpen} = 4'h0;
    addr = 8'h00; wrData = 32'h0; svcLen = 8'h00; cyc = 0; mon = 1;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`REG_TIMING, `OHMS_RST); rd(`REG_STATUS, 0);
    rd(8'h20, 0); rd(`REG_CLEAR, 0);
    wr(`REG_TIMING, 20); wr(`REG_IRQEN, 1);
    pg <= 1'b1; enReq <= 1'b1; refCyc = cyc;
    fault(8 * T, T / 5);
    chk("irq", 1, irq);
    rd(`REG_STATUS, 1);
    wr(`REG_CLEAR, 7);
    @(negedge mclk);
    chk("irq", 0, irq);
    wr(`REG_IRQEN, 0);
    service(0); service(30); fault(SVC, T / 5);
    chk("irq masked", 0, irq);
    service(0); service(T / 2 + 40); fault(T + SVC, T / 5);
    ratioSel <= 1'b1;
    service(0); service(40); service(16); fault(SVC, T / 5);
    typeSel <= 1'b1;
    service(0); service(16); service(T - 40); fault(T + SVC, T / 5);
    mon = 0;
    for (int k = 0; k < 2; k++) begin
      rShort <= (k == 0); rOpen <= (k == 1);
      repeat (8) @(negedge mclk);
      chk("resistor hold", 1, oe);
      @(posedge mclk);
      rShort <= 1'b0; rOpen <= 1'b0;
      waitOe(1'b0);
      repeat (20) @(posedge mclk);
    end
    rd(`REG_STATUS, 7);
    enReq <= 1'b0; rShort <= 1'b1;
    repeat (10) @(negedge mclk);
    chk("disabled", 0, oe);
    @(posedge mclk);
    rShort <= 1'b0; pg <= 1'b0; enReq <= 1'b1;
    scaleSel <= 1'b1; typeSel <= 1'b0;
    repeat (10) @(negedge mclk);
    chk("power low", 0, oe);
    @(posedge mclk);
    pg <= 1'b1; refCyc = cyc; mon = 1;
    fault(8 * 5 * T, T);
    chk("faults left", 0, dQ.size());
    print_verdict;
  end
endmodule // tb
